// >>> design/npic_cfg.svh
// register map, field positions, reset values and source codes of the
// nested priority interrupt controller; included by the top design file
// and by the bench
`ifndef NPIC_CFG_SVH
`define NPIC_CFG_SVH

`define NPIC_ADDR_NORM_VEC   32'hffff001c
`define NPIC_ADDR_PRIO_C     32'hffff0028
`define NPIC_ADDR_NEST_CTRL  32'hffff0030
`define NPIC_ADDR_TRIG_CFG   32'hffff0034
`define NPIC_ADDR_EDGE_CLR   32'hffff0038
`define NPIC_ADDR_NORM_ISL   32'hffff003c
`define NPIC_ADDR_FAST_VEC   32'hffff011c
`define NPIC_ADDR_FAST_ISL   32'hffff013c
`define NPIC_ADDR_NORM_EN    32'hffff0140
`define NPIC_ADDR_FAST_EN    32'hffff0144
`define NPIC_ADDR_EVT_STAT   32'hffff0148
`define NPIC_ADDR_EVT_MASK   32'hffff014c

`define NPIC_PRIO_C_MASK     32'h00007777
`define NPIC_PRIO_EXT3_LSB   12
`define NPIC_PRIO_EXT2_LSB   8
`define NPIC_PRIO_SER_LSB    4
`define NPIC_PRIO_TW_LSB     0
`define NPIC_NEST_NORM_BIT   0
`define NPIC_NEST_FAST_BIT   1
`define NPIC_TRIG_CFG_MASK   32'h000000ff
`define NPIC_CLR_EXT0_BIT    13
`define NPIC_CLR_EXT1_BIT    14
`define NPIC_CLR_EXT2_BIT    18
`define NPIC_CLR_EXT3_BIT    19
`define NPIC_VEC_BASE_LSB    7
`define NPIC_VEC_IDX_LSB     2
`define NPIC_ISL_NONE        4'h8

`define NPIC_RST_WORD        32'h00000000

`define NPIC_CODE_EXT0       5'h0b
`define NPIC_CODE_EXT1       5'h0c
`define NPIC_CODE_EXT2       5'h10
`define NPIC_CODE_EXT3       5'h11
`define NPIC_CODE_SER        5'h0a
`define NPIC_CODE_TW         5'h0e

`endif

// >>> design/npic_pkg.sv
// types shared by the interrupt controller files
// assumes nothing beyond a SystemVerilog compiler
package npic_pkg;
    typedef enum logic [1:0] {
        NPIC_TRIG_HIGH = 2'b00,
        NPIC_TRIG_LOW  = 2'b01,
        NPIC_TRIG_RISE = 2'b10,
        NPIC_TRIG_FALL = 2'b11
    } npic_trig_t;

    typedef enum logic [1:0] {
        NPIC_BUS_IDLE = 2'b01,
        NPIC_BUS_WR   = 2'b10
    } npic_bus_t;
endpackage

// >>> design/npic_trig_chan.sv
// one external interrupt input: level or edge trigger with edge latch
// assumes the pin is already synchronous to clk
`timescale 1ns/1ns
module npic_trig_chan (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       pin,
    input  wire logic [1:0] mode,
    input  wire logic       clr,
    output logic            req,
    output logic            edge_evt
);
    logic prev_q;
    logic latch_q;
    logic latch_d;
    logic is_edge;
    logic hit;

    // mode[1] picks edge, mode[0] picks low level or falling edge
    assign is_edge  = mode[1];
    assign hit      = is_edge & (mode[0] ? (prev_q & ~pin)
                                         : (~prev_q & pin));
    assign edge_evt = hit;
    // a new edge in the clearing cycle is kept
    assign latch_d  = is_edge & (hit | (latch_q & ~clr));
    assign req      = is_edge ? latch_q
                              : (mode[0] ? ~pin : pin);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_q  <= 1'b0;
            latch_q <= 1'b0;
        end else begin
            prev_q  <= pin;
            latch_q <= latch_d;
        end
    end

    chk_edge_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (latch_q && !clr && is_edge) |=> latch_q)
        else $error("edge request dropped without a clear");
    chk_level_follow: assert property (@(posedge clk) disable iff (!rst_n)
        !is_edge |-> (req == (pin ^ mode[0])))
        else $error("level request does not follow the pin");
endmodule

// >>> design/npic_pick.sv
// picks the most urgent pending source that is not blocked
// assumes levels packed lsb first, threshold 8 meaning nothing in service
`timescale 1ns/1ns
module npic_pick #(
    parameter int N  = 6,
    parameter int LW = 3,
    parameter int IW = 3
) (
    input  wire logic [N-1:0]    pend,
    input  wire logic [N*LW-1:0] levels,
    input  wire logic [LW:0]     thr,
    output logic                 valid,
    output logic [IW-1:0]        idx,
    output logic [LW-1:0]        lvl
);
    always_comb begin
        logic [LW-1:0] lv;
        lv    = '0;
        valid = 1'b0;
        idx   = '0;
        lvl   = '0;
        for (int i = 0; i < N; i++) begin
            lv = levels[i*LW +: LW];
            // strictly lower level wins, so ties keep the lowest index
            if (pend[i] && ({1'b0, lv} < thr)
                && (!valid || lv < lvl)) begin
                valid = 1'b1;
                idx   = IW'(i);
                lvl   = lv;
            end
        end
    end
endmodule

// >>> design/npic_top.sv
// nested priority interrupt controller: AHB-Lite register slave,
// external trigger channels, normal and fast arbitration, in-service
// levels and an event interrupt.
// assumes a single AHB-Lite master doing whole-word single transfers.
//
// How it works
// - external pins 3 and 2 keep 3-bit levels at bits 14:12, 10:8
// - serial and two-wire slave sources keep 3-bit levels at 6:4, 2:0
// - control bit 0 turns on nesting and levels for normal requests
// - control bit 1 turns on nesting and levels for fast requests
// - fast always reaches the core; normal only while no fast one stands
// - normal vector read with nesting sets in-service bit of served level
// - fast vector read with nesting sets in-service bit of served level
// - a set in-service bit blocks that level and all less urgent ones
// - each in-service write clears just the most urgent set bit
// - fast vector: zeros, base in 22:7, source code in 6:2
// - four external inputs: high, low, rising or falling trigger
// - edge request latched until software clears it
// - 2-bit trigger field per input at bits 1:0, 3:2, 5:4, 7:6
// - clear bits 13, 14, 18, 19 drop edge latches of inputs 0 to 3
// - level 0 most urgent, level 7 least urgent
`timescale 1ns/1ns
`include "npic_cfg.svh"
module npic_top #(
    parameter int NSRC = 6,
    parameter int NEXT = 4
) (
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic [31:0]      HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic [3:0]  EXT_INT,
    input  wire logic        SERIAL_SLAVE_REQ,
    input  wire logic        TWOWIRE_SLAVE_REQ,
    input  wire logic [2:0]  EXT0_PRIORITY,
    input  wire logic [2:0]  EXT1_PRIORITY,
    input  wire logic [15:0] VECTOR_TABLE_BASE,
    output logic             NORMAL_REQ,
    output logic             FAST_REQ,
    output logic             INT_OUT
);
    npic_pkg::npic_bus_t bus_q;
    npic_pkg::npic_bus_t bus_d;
    logic [31:0]         waddr_q;
    logic [31:0]         rdata_q;
    logic [31:0]         prio_q;
    logic [1:0]          nest_q;
    logic [7:0]          trig_q;
    logic [NSRC-1:0]     nen_q;
    logic [NSRC-1:0]     fen_q;
    logic [7:0]          nisl_q;
    logic [7:0]          nisl_d;
    logic [7:0]          fisl_q;
    logic [7:0]          fisl_d;
    logic [NEXT-1:0]     evt_q;
    logic [NEXT-1:0]     evt_d;
    logic [NEXT-1:0]     emask_q;

    // address phase: reads are answered from a register with no wait
    logic accept;
    logic rd_acc;
    logic wr_acc;
    logic wr_now;
    assign accept = HSEL & HTRANS[1] & HREADY;
    assign rd_acc = accept & ~HWRITE;
    assign wr_acc = accept & HWRITE;
    assign wr_now = (bus_q == npic_pkg::NPIC_BUS_WR);
    assign bus_d  = wr_acc ? npic_pkg::NPIC_BUS_WR : npic_pkg::NPIC_BUS_IDLE;

    logic ra_prio;
    logic ra_nest;
    logic ra_trig;
    logic ra_nisl;
    logic ra_fisl;
    logic ra_nvec;
    logic ra_fvec;
    logic ra_nen;
    logic ra_fen;
    logic ra_evt;
    logic ra_emask;
    assign ra_prio  = HADDR == `NPIC_ADDR_PRIO_C;
    assign ra_nest  = HADDR == `NPIC_ADDR_NEST_CTRL;
    assign ra_trig  = HADDR == `NPIC_ADDR_TRIG_CFG;
    assign ra_nisl  = HADDR == `NPIC_ADDR_NORM_ISL;
    assign ra_fisl  = HADDR == `NPIC_ADDR_FAST_ISL;
    assign ra_nvec  = HADDR == `NPIC_ADDR_NORM_VEC;
    assign ra_fvec  = HADDR == `NPIC_ADDR_FAST_VEC;
    assign ra_nen   = HADDR == `NPIC_ADDR_NORM_EN;
    assign ra_fen   = HADDR == `NPIC_ADDR_FAST_EN;
    assign ra_evt   = HADDR == `NPIC_ADDR_EVT_STAT;
    assign ra_emask = HADDR == `NPIC_ADDR_EVT_MASK;

    logic wh_prio;
    logic wh_nest;
    logic wh_trig;
    logic wh_clr;
    logic wh_nisl;
    logic wh_fisl;
    logic wh_nen;
    logic wh_fen;
    logic wh_emask;
    assign wh_prio  = wr_now & (waddr_q == `NPIC_ADDR_PRIO_C);
    assign wh_nest  = wr_now & (waddr_q == `NPIC_ADDR_NEST_CTRL);
    assign wh_trig  = wr_now & (waddr_q == `NPIC_ADDR_TRIG_CFG);
    assign wh_clr   = wr_now & (waddr_q == `NPIC_ADDR_EDGE_CLR);
    assign wh_nisl  = wr_now & (waddr_q == `NPIC_ADDR_NORM_ISL);
    assign wh_fisl  = wr_now & (waddr_q == `NPIC_ADDR_FAST_ISL);
    assign wh_nen   = wr_now & (waddr_q == `NPIC_ADDR_NORM_EN);
    assign wh_fen   = wr_now & (waddr_q == `NPIC_ADDR_FAST_EN);
    assign wh_emask = wr_now & (waddr_q == `NPIC_ADDR_EVT_MASK);

    // external channels
    logic [NEXT-1:0] ext_req;
    logic [NEXT-1:0] ext_evt;
    logic [NEXT-1:0] ext_clr;
    genvar g;
    generate
        for (g = 0; g < NEXT; g++) begin : g_ext
            localparam int CPOS = (g == 0) ? `NPIC_CLR_EXT0_BIT :
                                  (g == 1) ? `NPIC_CLR_EXT1_BIT :
                                  (g == 2) ? `NPIC_CLR_EXT2_BIT :
                                             `NPIC_CLR_EXT3_BIT;
            assign ext_clr[g] = wh_clr & HWDATA[CPOS];
            npic_trig_chan u_chan (
                .clk      (CLK_SYS),
                .rst_n    (RST_N),
                .pin      (EXT_INT[g]),
                .mode     (trig_q[2*g +: 2]),
                .clr      (ext_clr[g]),
                .req      (ext_req[g]),
                .edge_evt (ext_evt[g])
            );
        end
    endgenerate

    // sources: ext0..ext3, serial slave, two-wire slave
    logic [NSRC-1:0]   src_req;
    logic [NSRC*3-1:0] lvl_raw;
    logic [NSRC*3-1:0] lvl_n;
    logic [NSRC*3-1:0] lvl_f;
    assign src_req = {TWOWIRE_SLAVE_REQ, SERIAL_SLAVE_REQ, ext_req};
    assign lvl_raw = {prio_q[`NPIC_PRIO_TW_LSB +: 3],
                      prio_q[`NPIC_PRIO_SER_LSB +: 3],
                      prio_q[`NPIC_PRIO_EXT3_LSB +: 3],
                      prio_q[`NPIC_PRIO_EXT2_LSB +: 3],
                      EXT1_PRIORITY,
                      EXT0_PRIORITY};
    // without nesting every source counts as level 0: index order only
    assign lvl_n = nest_q[`NPIC_NEST_NORM_BIT] ? lvl_raw : '0;
    assign lvl_f = nest_q[`NPIC_NEST_FAST_BIT] ? lvl_raw : '0;

    function automatic logic [3:0] first_set(input logic [7:0] v);
        first_set = `NPIC_ISL_NONE;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                first_set = 4'(i);
            end
        end
    endfunction

    function automatic logic [4:0] src_code(input logic [2:0] i);
        case (i)
            3'h0:    src_code = `NPIC_CODE_EXT0;
            3'h1:    src_code = `NPIC_CODE_EXT1;
            3'h2:    src_code = `NPIC_CODE_EXT2;
            3'h3:    src_code = `NPIC_CODE_EXT3;
            3'h4:    src_code = `NPIC_CODE_SER;
            default: src_code = `NPIC_CODE_TW;
        endcase
    endfunction

    logic [3:0] thr_n;
    logic [3:0] thr_f;
    logic       nvalid;
    logic       fvalid;
    logic [2:0] nidx;
    logic [2:0] fidx;
    logic [2:0] nlvl;
    logic [2:0] flvl;
    // bit 0 is most urgent, so the lowest set bit is the blocking level
    assign thr_n = first_set(nisl_q);
    assign thr_f = first_set(fisl_q);

    npic_pick #(.N(NSRC), .LW(3), .IW(3)) u_pick_n (
        .pend   (src_req & nen_q),
        .levels (lvl_n),
        .thr    (thr_n),
        .valid  (nvalid),
        .idx    (nidx),
        .lvl    (nlvl)
    );
    npic_pick #(.N(NSRC), .LW(3), .IW(3)) u_pick_f (
        .pend   (src_req & fen_q),
        .levels (lvl_f),
        .thr    (thr_f),
        .valid  (fvalid),
        .idx    (fidx),
        .lvl    (flvl)
    );

    // the core never sees a normal request while a fast one stands
    assign FAST_REQ   = fvalid;
    assign NORMAL_REQ = nvalid & ~fvalid;

    logic [31:0] nvec;
    logic [31:0] fvec;
    assign nvec = {9'h000, VECTOR_TABLE_BASE, src_code(nidx), 2'b00};
    assign fvec = {9'h000, VECTOR_TABLE_BASE, src_code(fidx), 2'b00};

    // in-service levels: a vector read pushes, a write pops the top bit
    logic       set_n;
    logic       set_f;
    logic [7:0] pop_n;
    logic [7:0] pop_f;
    assign set_n  = rd_acc & ra_nvec & nest_q[`NPIC_NEST_NORM_BIT]
                    & nvalid;
    assign set_f  = rd_acc & ra_fvec & nest_q[`NPIC_NEST_FAST_BIT]
                    & fvalid;
    assign pop_n  = nisl_q & (nisl_q - 8'h01);
    assign pop_f  = fisl_q & (fisl_q - 8'h01);
    assign nisl_d = (wh_nisl ? pop_n : nisl_q)
                    | (set_n ? (8'h01 << nlvl) : 8'h00);
    assign fisl_d = (wh_fisl ? pop_f : fisl_q)
                    | (set_f ? (8'h01 << flvl) : 8'h00);

    // event status: an edge in the clearing read is not lost
    assign evt_d   = ext_evt | (evt_q & ~((rd_acc & ra_evt) ?
                                          {NEXT{1'b1}} : {NEXT{1'b0}}));
    assign INT_OUT = |(evt_q & emask_q);

    logic [31:0] rd_mux;
    assign rd_mux = ({32{ra_prio}}  & prio_q)
                  | ({32{ra_nest}}  & {30'h0, nest_q})
                  | ({32{ra_trig}}  & {24'h0, trig_q})
                  | ({32{ra_nisl}}  & {24'h0, nisl_q})
                  | ({32{ra_fisl}}  & {24'h0, fisl_q})
                  | ({32{ra_nvec}}  & nvec)
                  | ({32{ra_fvec}}  & fvec)
                  | ({32{ra_nen}}   & {26'h0, nen_q})
                  | ({32{ra_fen}}   & {26'h0, fen_q})
                  | ({32{ra_evt}}   & {28'h0, evt_q})
                  | ({32{ra_emask}} & {28'h0, emask_q});

    assign HRDATA    = rdata_q;
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            bus_q   <= npic_pkg::NPIC_BUS_IDLE;
            waddr_q <= `NPIC_RST_WORD;
            rdata_q <= `NPIC_RST_WORD;
        end else begin
            bus_q   <= bus_d;
            waddr_q <= wr_acc ? HADDR : waddr_q;
            rdata_q <= rd_acc ? rd_mux : rdata_q;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            prio_q  <= `NPIC_RST_WORD;
            nest_q  <= 2'h0;
            trig_q  <= 8'h00;
            nen_q   <= '0;
            fen_q   <= '0;
        end else begin
            if (wh_prio) prio_q <= HWDATA & `NPIC_PRIO_C_MASK;
            if (wh_nest) nest_q <= HWDATA[1:0];
            if (wh_trig) trig_q <= HWDATA[7:0];
            if (wh_nen)  nen_q  <= HWDATA[NSRC-1:0];
            if (wh_fen)  fen_q  <= HWDATA[NSRC-1:0];
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            nisl_q  <= 8'h00;
            fisl_q  <= 8'h00;
            evt_q   <= '0;
            emask_q <= '0;
        end else begin
            nisl_q  <= nisl_d;
            fisl_q  <= fisl_d;
            evt_q   <= evt_d;
            if (wh_emask) emask_q <= HWDATA[NEXT-1:0];
        end
    end

    sequence s_fvec_read;
        rd_acc && ra_fvec && nest_q[1] && fvalid && !wh_fisl;
    endsequence
    sequence s_nvec_read;
        rd_acc && ra_nvec && nest_q[0] && nvalid && !wh_nisl;
    endsequence

    chk_nvec_sets_bit: assert property (@(posedge CLK_SYS)
        disable iff (!RST_N)
        s_nvec_read |=> nisl_q[$past(nlvl)])
        else $error("normal vector read did not mark its level");
    chk_fvec_sets_bit: assert property (@(posedge CLK_SYS)
        disable iff (!RST_N)
        s_fvec_read |=> fisl_q[$past(flvl)])
        else $error("fast vector read did not mark its level");
    chk_isl_pop_one: assert property (@(posedge CLK_SYS)
        disable iff (!RST_N)
        (wh_nisl && !set_n) |=> nisl_q == ($past(nisl_q)
                                & ($past(nisl_q) - 8'h01)))
        else $error("in-service write did not clear exactly one bit");
    chk_fast_first: assert property (@(posedge CLK_SYS)
        disable iff (!RST_N)
        FAST_REQ |-> !NORMAL_REQ)
        else $error("normal request shown beside a fast one");
    chk_nonest_noset: assert property (@(posedge CLK_SYS)
        disable iff (!RST_N)
        (!nest_q[0] && !wh_nisl && nisl_q == 8'h00) |=> nisl_q == 8'h00)
        else $error("in-service level set with nesting off");
    chk_block_level: assert property (@(posedge CLK_SYS)
        disable iff (!RST_N)
        nvalid |-> (nisl_q & ((8'h02 << nlvl) - 8'h01)) == 8'h00)
        else $error("blocked level still presented");
    chk_fvec_layout: assert property (@(posedge CLK_SYS)
        disable iff (!RST_N)
        (rd_acc && ra_fvec) |=> (HRDATA[31:23] == 9'h000
            && HRDATA[1:0] == 2'b00
            && HRDATA[22:7] == $past(VECTOR_TABLE_BASE)))
        else $error("fast vector read returned a bad layout");
    chk_int_out_mask: assert property (@(posedge CLK_SYS)
        disable iff (!RST_N)
        (ext_evt != '0 && (ext_evt & emask_q) != '0
         && !wh_emask) |=> ##[0:1] INT_OUT)
        else $error("unmasked event did not raise the interrupt");
endmodule

// >>> tb/npic_core_model.sv
// stand-in for the processor core that takes normal and fast requests
// assumes the request lines are synchronous to clk
`timescale 1ns/1ns
module npic_core_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic normal_req,
    input  wire logic fast_req,
    output logic      normal_taken,
    output logic      fast_taken
);
    // software on this core reads a vector only once the matching
    // request has been taken; the bench checks one before the first vector read of each nesting pass
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            normal_taken <= 1'b0;
            fast_taken   <= 1'b0;
        end else begin
            fast_taken   <= fast_req;
            normal_taken <= normal_req & ~fast_req;
        end
    end
endmodule

// >>> tb/npic_tb.sv
// self-checking bench: AHB-Lite master tasks, pin stimulus, core model
// assumes the controller answers with zero wait states or within 50
`timescale 1ns/1ns
`include "npic_cfg.svh"
module nested_priority_interrupt_ctrl_tb;
    logic        CLK_SYS = 1'b0;
    logic        RST_N = 1'b0;
    logic        HSEL = 1'b0;
    logic [31:0] HADDR = 32'h0;
    logic [1:0]  HTRANS = 2'b00;
    logic        HWRITE = 1'b0;
    logic [2:0]  HSIZE = 3'h2;
    logic [31:0] HWDATA = 32'h0;
    logic [3:0]  EXT_INT = 4'h0;
    logic        SERIAL_SLAVE_REQ = 1'b0;
    logic        TWOWIRE_SLAVE_REQ = 1'b0;
    logic [2:0]  EXT0_PRIORITY = 3'h0;
    logic [2:0]  EXT1_PRIORITY = 3'h0;
    logic [15:0] VECTOR_TABLE_BASE = 16'h0;
    wire  [31:0] HRDATA;
    wire         HREADY, HREADYOUT, HRESP, NORMAL_REQ, FAST_REQ, INT_OUT;
    wire         normal_taken, fast_taken;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          seed = 32'hc096;
    logic [31:0] rv, va, ia, ea;

    assign HREADY = HREADYOUT;
    always #4 CLK_SYS = ~CLK_SYS;

    npic_top #(.NSRC(6), .NEXT(4)) u_dut (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
        .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
        .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .EXT_INT(EXT_INT),
        .SERIAL_SLAVE_REQ(SERIAL_SLAVE_REQ),
        .TWOWIRE_SLAVE_REQ(TWOWIRE_SLAVE_REQ),
        .EXT0_PRIORITY(EXT0_PRIORITY), .EXT1_PRIORITY(EXT1_PRIORITY),
        .VECTOR_TABLE_BASE(VECTOR_TABLE_BASE), .NORMAL_REQ(NORMAL_REQ),
        .FAST_REQ(FAST_REQ), .INT_OUT(INT_OUT));

    npic_core_model u_core (.clk(CLK_SYS), .rst_n(RST_N),
        .normal_req(NORMAL_REQ), .fast_req(FAST_REQ),
        .normal_taken(normal_taken), .fast_taken(fast_taken));

    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: read %h not %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: line %b not %b", $time, got, exp);
        end
    endtask

    // a hang counts as a mismatch and closes the run
    task automatic wait_rdy;
        int k;
        k = 0;
        @(posedge CLK_SYS);
        while (HREADY !== 1'b1) begin
            k++;
            if (k > 50) begin
                n_mismatch++;
                $display("CHECK FAILED at %0t: bus never ready", $time);
                end_sim;
            end
            @(posedge CLK_SYS);
        end
    endtask

    task automatic bus(input logic w, input logic [31:0] a, d,
                       output logic [31:0] r);
        @(posedge CLK_SYS);
        HSEL   <= 1'b1;
        HTRANS <= 2'b10;
        HWRITE <= w;
        HADDR  <= a;
        wait_rdy;
        HTRANS <= 2'b00;
        HWDATA <= d;
        wait_rdy;
        r = HRDATA;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
        chk1(HRESP, 1'b0);
    endtask

    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk32(r, exp);
    endtask

    // outputs are looked at mid-cycle, well clear of the edges
    task automatic look;
        repeat (2) @(posedge CLK_SYS);
        @(negedge CLK_SYS);
    endtask

    task automatic reqc(input logic f, input logic e);
        look;
        chk1(f ? FAST_REQ : NORMAL_REQ, e);
    endtask

    function automatic logic [31:0] vec(input logic [4:0] c);
        return {9'h0, VECTOR_TABLE_BASE, c, 2'b00};
    endfunction

    function automatic logic [31:0] clrb(input int i);
        return 32'h1 << (i == 0 ? 13 : i == 1 ? 14 : i == 2 ? 18 : 19);
    endfunction

    initial begin
        rv = $random(seed);
        repeat (4) @(posedge CLK_SYS);
        RST_N             <= 1'b1;
        VECTOR_TABLE_BASE <= rv[15:0];
        EXT0_PRIORITY     <= rv[18:16];
        EXT1_PRIORITY     <= rv[21:19];
        rdc(`NPIC_ADDR_PRIO_C, 32'h0);
        rdc(`NPIC_ADDR_NEST_CTRL, 32'h0);
        rdc(`NPIC_ADDR_TRIG_CFG, 32'h0);
        rdc(`NPIC_ADDR_NORM_ISL, 32'h0);
        rdc(`NPIC_ADDR_FAST_ISL, 32'h0);
        repeat (4) begin
            rv = $random(seed);
            wr(`NPIC_ADDR_PRIO_C, rv);
            rdc(`NPIC_ADDR_PRIO_C, rv & `NPIC_PRIO_C_MASK);
            wr(`NPIC_ADDR_NEST_CTRL, rv);
            rdc(`NPIC_ADDR_NEST_CTRL, rv & 32'h3);
            wr(`NPIC_ADDR_TRIG_CFG, rv);
            rdc(`NPIC_ADDR_TRIG_CFG, rv & `NPIC_TRIG_CFG_MASK);
        end
        wr(32'hffff0000, 32'hffffffff);
        rdc(32'hffff0000, 32'h0);
        rdc(`NPIC_ADDR_EDGE_CLR, 32'h0);
        wr(`NPIC_ADDR_NEST_CTRL, 32'h0);
        wr(`NPIC_ADDR_NORM_EN, 32'h10);
        wr(`NPIC_ADDR_FAST_EN, 32'h20);
        @(posedge CLK_SYS);
        SERIAL_SLAVE_REQ  <= 1'b1;
        TWOWIRE_SLAVE_REQ <= 1'b1;
        reqc(1'b1, 1'b1);
        reqc(1'b0, 1'b0);
        @(posedge CLK_SYS);
        TWOWIRE_SLAVE_REQ <= 1'b0;
        reqc(1'b0, 1'b1);
        @(posedge CLK_SYS);
        SERIAL_SLAVE_REQ <= 1'b0;
        wr(`NPIC_ADDR_NORM_EN, 32'h0);
        for (int i = 0; i < 4; i++) begin
            for (int m = 0; m < 4; m++) begin
                @(posedge CLK_SYS);
                EXT_INT[i] <= m[0];
                wr(`NPIC_ADDR_FAST_EN, 32'h1 << i);
                wr(`NPIC_ADDR_TRIG_CFG, m << (2 * i));
                wr(`NPIC_ADDR_EDGE_CLR, 32'h000c6000);
                reqc(1'b1, 1'b0);
                @(posedge CLK_SYS);
                EXT_INT[i] <= ~m[0];
                reqc(1'b1, 1'b1);
                @(posedge CLK_SYS);
                EXT_INT[i] <= m[0];
                reqc(1'b1, m[1]);
                if (m[1]) begin
                    wr(`NPIC_ADDR_EDGE_CLR, 32'h000c6000 & ~clrb(i));
                    reqc(1'b1, 1'b1);
                    wr(`NPIC_ADDR_EDGE_CLR, clrb(i));
                    reqc(1'b1, 1'b0);
                end
            end
        end
        @(posedge CLK_SYS);
        EXT_INT <= 4'h0;
        wr(`NPIC_ADDR_FAST_EN, 32'h0);
        wr(`NPIC_ADDR_TRIG_CFG, 32'h2);
        wr(`NPIC_ADDR_EVT_MASK, 32'h1);
        bus(1'b0, `NPIC_ADDR_EVT_STAT, 32'h0, rv);
        look;
        chk1(INT_OUT, 1'b0);
        @(posedge CLK_SYS);
        EXT_INT[0] <= 1'b1;
        look;
        chk1(INT_OUT, 1'b1);
        rdc(`NPIC_ADDR_EVT_STAT, 32'h1);
        look;
        chk1(INT_OUT, 1'b0);
        wr(`NPIC_ADDR_EVT_MASK, 32'h0);
        @(posedge CLK_SYS);
        EXT_INT[0] <= 1'b0;
        @(posedge CLK_SYS);
        EXT_INT[0] <= 1'b1;
        look;
        chk1(INT_OUT, 1'b0);
        rdc(`NPIC_ADDR_EVT_STAT, 32'h1);
        for (int t = 0; t < 2; t++) begin
            va = t ? `NPIC_ADDR_FAST_VEC : `NPIC_ADDR_NORM_VEC;
            ia = t ? `NPIC_ADDR_FAST_ISL : `NPIC_ADDR_NORM_ISL;
            ea = t ? `NPIC_ADDR_FAST_EN : `NPIC_ADDR_NORM_EN;
            wr(`NPIC_ADDR_NEST_CTRL, 32'h1 << t);
            wr(ea, 32'h30);
            wr(`NPIC_ADDR_PRIO_C, 32'h53);
            @(posedge CLK_SYS);
            SERIAL_SLAVE_REQ  <= 1'b1;
            TWOWIRE_SLAVE_REQ <= 1'b1;
            reqc(t[0], 1'b1);
            chk1(t ? fast_taken : normal_taken, 1'b1);
            rdc(va, vec(`NPIC_CODE_TW));
            rdc(ia, 32'h08);
            reqc(t[0], 1'b0);
            wr(`NPIC_ADDR_PRIO_C, 32'h50);
            reqc(t[0], 1'b1);
            rdc(va, vec(`NPIC_CODE_TW));
            rdc(ia, 32'h09);
            wr(ia, 32'hff);
            rdc(ia, 32'h08);
            @(posedge CLK_SYS);
            TWOWIRE_SLAVE_REQ <= 1'b0;
            reqc(t[0], 1'b0);
            wr(ia, 32'hff);
            rdc(ia, 32'h00);
            reqc(t[0], 1'b1);
            rdc(va, vec(`NPIC_CODE_SER));
            rdc(ia, 32'h20);
            wr(ia, 32'hff);
            wr(ea, 32'h0);
            @(posedge CLK_SYS);
            SERIAL_SLAVE_REQ <= 1'b0;
        end
        // nesting off: levels ignored, lowest index wins, no push
        wr(`NPIC_ADDR_NEST_CTRL, 32'h0);
        wr(`NPIC_ADDR_NORM_EN, 32'h30);
        @(posedge CLK_SYS);
        SERIAL_SLAVE_REQ  <= 1'b1;
        TWOWIRE_SLAVE_REQ <= 1'b1;
        reqc(1'b0, 1'b1);
        rdc(`NPIC_ADDR_NORM_VEC, vec(`NPIC_CODE_SER));
        rdc(`NPIC_ADDR_NORM_ISL, 32'h0);
        // input 0 still holds its rising-edge latch from the event test
        wr(`NPIC_ADDR_NORM_EN, 32'h31);
        rdc(`NPIC_ADDR_NORM_VEC, vec(`NPIC_CODE_EXT0));
        // pins 3 and 2 at levels 1 and 2: level beats the lower index
        @(posedge CLK_SYS);
        EXT_INT[3:2] <= 2'b11;
        wr(`NPIC_ADDR_NEST_CTRL, 32'h1);
        wr(`NPIC_ADDR_PRIO_C, 32'h1200);
        wr(`NPIC_ADDR_NORM_EN, 32'h0c);
        rdc(`NPIC_ADDR_NORM_VEC, vec(`NPIC_CODE_EXT3));
        rdc(`NPIC_ADDR_NORM_ISL, 32'h02);
        reqc(1'b0, 1'b0);
        end_sim;
    end
endmodule
